// File: rtl/efrm_monitor.sv
// Encoder fault reaction monitor with Wishbone registers
//
// Register access over Wishbone and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "efrm_params.svh"

// Summary of operation
// RULE1 - Configured reaction: torque off, on demand, estimate
// RULE2 - Confirm pulse count over eleven revolutions (twelve index pulses)
// RULE3 - Immediate mode: fail-safe, faults, torque off
// RULE4 - On demand: fault once safety function active
// RULE5 - On demand, no function active: no trip
// RULE6 - Fail-safe latches until module reboot
// RULE7 - Estimate mode: warnings and channel events only
// RULE8 - Estimate mode: supervise on estimated speed
// RULE9 - Lock drive-side encoder configuration values
// RULE10 - Manual or automatic acknowledgement selectable
// RULE11 - Either lost channel requests the function
// RULE12 - Discrepancy warning while channels disagree
// RULE13 - Ack refused until joint request and release
// RULE14 - Early acknowledgement attempts are rejected
// RULE15 - Encoder loss acted on within bounded cycles
module efrm_monitor
    import efrm_pkg::*;
#(
    parameter int LOSS_CYC = `EFRM_LOSS_CYC,
    parameter int Z_REVS   = `EFRM_Z_REVS
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,

    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,

    // Encoder channels and index pulse
    input  wire logic        enc_ch1_i,
    input  wire logic        enc_ch2_i,
    input  wire logic        enc_pulse_i,
    input  wire logic        enc_z_i,

    // Safety function activity
    input  wire logic        sf_active_i,
    input  wire logic        sf_exempt_i,

    // Redundant input pair and ack button
    input  wire logic        red_ch_a_i,
    input  wire logic        red_ch_b_i,
    input  wire logic        ack_button_i,

    // Drive side
    output logic             sto_o,
    output logic             use_estimate_o,
    output logic             cfg_lock_o,
    output logic             sf_request_o,
    output logic             sf_acked_o,
    output logic             irq_o
);
    localparam int LW = $clog2(LOSS_CYC + 1);

    typedef struct packed {
        logic [31:0]         dat;
        logic                ack;
        logic                err;
        logic [1:0]          react;
        logic                auto_ack;
        logic                lock;

        logic [15:0]         ppr;
        logic [15:0]         pcnt;
        logic [15:0]         plast;
        logic [3:0]          zcnt;
        logic                ppr_ok;
        logic                zd;
        logic [LW-1:0]       loss;

        efrm_mode_t          mode;
        logic [`EFRM_NEV-1:0] ev;
        logic [`EFRM_NEV-1:0] msk;

        logic                sto;
        logic                est;
        logic                sf_req;
        logic                sf_ack;
        logic                ack_d;
        logic                irq;
    } efrm_state_t;

    efrm_state_t st_ff;
    efrm_state_t nxt_st;
    efrm_ri_if   ri ();

    assign ri.ch_a = red_ch_a_i;
    assign ri.ch_b = red_ch_b_i;

    efrm_redund u_redund (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ri    (ri)
    );

    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    function automatic logic [31:0] efrm_merge(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic efrm_hit(input logic [7:0] adr,
                                      input logic [7:0] off);
        return adr == off;
    endfunction

    logic [31:0]         ctrl_rd;
    logic [31:0]         stat_rd;
    logic [`EFRM_NEV-1:0] ev_set;
    logic                enc_lost;
    logic [31:0]         ctrl_w;
    logic [31:0]         msk_w;
    logic [31:0]         ppr_w;
    logic [31:0]         clr_w;
    logic                ack_req;

    assign ctrl_rd = {27'h0, st_ff.lock, 1'b0, st_ff.auto_ack, st_ff.react};
    assign stat_rd = {20'h0, ri.ack_ok, ri.discrep, ri.request,
                      st_ff.sf_ack, st_ff.est, st_ff.sto, st_ff.ppr_ok,
                      st_ff.zcnt == 4'h0, st_ff.mode, 2'h0};
    assign enc_lost = !(enc_ch1_i && enc_ch2_i);

    // Byte-lane merges of the write data, one per writable register
    assign ctrl_w = efrm_merge(ctrl_rd, wb_dat_i, wb_sel_i);
    assign msk_w  = efrm_merge({22'h0, st_ff.msk}, wb_dat_i, wb_sel_i);
    assign ppr_w  = efrm_merge({16'h0, st_ff.ppr}, wb_dat_i, wb_sel_i);
    assign clr_w  = efrm_merge(32'h0, wb_dat_i, wb_sel_i);

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    always_comb begin
        nxt_st     = st_ff;
        ev_set     = '0;
        ack_req    = 1'b0;
        nxt_st.ack = 1'b0;
        nxt_st.err = 1'b0;

        // Bus: one wait state, ack drops in the cycle after it is given
        if (wb_cyc_i && wb_stb_i && !st_ff.ack && !st_ff.err) begin
            nxt_st.ack = 1'b1;
            nxt_st.dat = 32'h0;
            if (efrm_hit(wb_adr_i, `EFRM_OFF_CTRL)) begin
                nxt_st.dat = ctrl_rd;
                if (wb_we_i) begin
                    nxt_st.react = ctrl_w[`EFRM_CTRL_REACT_LSB +: 2]; // [RULE1]
                    nxt_st.auto_ack = ctrl_w[`EFRM_CTRL_AUTO_ACK]; // [RULE10]
                    nxt_st.lock     = ctrl_w[`EFRM_CTRL_LOCK];
                    ack_req         = ctrl_w[`EFRM_CTRL_ACK] && wb_sel_i[0];
                end
            end else if (efrm_hit(wb_adr_i, `EFRM_OFF_STATUS)) begin
                nxt_st.dat = stat_rd;
            end else if (efrm_hit(wb_adr_i, `EFRM_OFF_IRQ_ST)) begin
                nxt_st.dat = {22'h0, st_ff.ev};
            end else if (efrm_hit(wb_adr_i, `EFRM_OFF_IRQ_MSK)) begin
                nxt_st.dat = {22'h0, st_ff.msk};
                if (wb_we_i) begin
                    nxt_st.msk = msk_w[`EFRM_NEV-1:0];
                end
            end else if (efrm_hit(wb_adr_i, `EFRM_OFF_PPR)) begin
                nxt_st.dat = {16'h0, st_ff.ppr};
                // Drive-side copy is frozen while locked
                if (wb_we_i && !st_ff.lock) begin // [RULE9]
                    nxt_st.ppr = ppr_w[15:0];
                    nxt_st.ppr_ok = 1'b0;
                end
            end else if (efrm_hit(wb_adr_i, `EFRM_OFF_PCNT)) begin
                nxt_st.dat = {16'h0, st_ff.plast};
            end else begin
                nxt_st.ack = 1'b0;
                nxt_st.err = 1'b1;
            end
        end


        // Pulse count check: pulses counted between index pulses
        nxt_st.zd = enc_z_i;
        if (enc_pulse_i) begin
            nxt_st.pcnt = st_ff.pcnt + 16'h1;
        end
        if (enc_z_i && !st_ff.zd) begin
            // The pulse beside the index edge opens the new revolution
            nxt_st.pcnt = {15'h0, enc_pulse_i};
            if (st_ff.zcnt != 4'h0) begin
                nxt_st.plast = st_ff.pcnt;
            end
            if (st_ff.zcnt != 4'h0 && st_ff.pcnt != st_ff.ppr) begin
                nxt_st.zcnt = 4'h0;
            end else if (int'(st_ff.zcnt) == Z_REVS) begin // [RULE2]
                if (!st_ff.ppr_ok) begin
                    ev_set[`EFRM_EV_PPR_OK] = 1'b1;
                end
                nxt_st.ppr_ok = 1'b1;
            end else begin
                nxt_st.zcnt = st_ff.zcnt + 4'h1;
            end
        end


        // Loss filter gives a fixed reaction delay
        if (!enc_lost) begin
            nxt_st.loss = '0;
        end else if (int'(st_ff.loss) != LOSS_CYC) begin // [RULE15]
            nxt_st.loss = st_ff.loss + LW'(1);
        end


        case (st_ff.mode)
            EFRM_RUN: begin
                if (int'(st_ff.loss) == LOSS_CYC) begin
                    case (st_ff.react)
                        `EFRM_REACT_STO: begin
                            nxt_st.mode = EFRM_FAILSAFE;       // [RULE3]
                            ev_set[`EFRM_EV_GEN_FAULT]  = 1'b1;
                            ev_set[`EFRM_EV_COMM_FAULT] = 1'b1;
                        end

                        `EFRM_REACT_DEMAND: begin
                            // No function asked for: keep running
                            if (sf_active_i && !sf_exempt_i) begin // [RULE4] [RULE5]
                                nxt_st.mode = EFRM_FAILSAFE;
                                ev_set[`EFRM_EV_GEN_FAULT] = 1'b1;
                                ev_set[`EFRM_EV_ENC_FAULT] = 1'b1;
                            end
                        end

                        `EFRM_REACT_ESTIMATE: begin
                            nxt_st.mode = EFRM_FALLBACK;       // [RULE7]
                            ev_set[`EFRM_EV_ENC_WARN] = 1'b1;
                            ev_set[`EFRM_EV_GEN_WARN] = 1'b1;
                            ev_set[`EFRM_EV_CH1_DIAG] = !enc_ch1_i;
                            ev_set[`EFRM_EV_CH2_DIAG] = !enc_ch2_i;
                        end
                        default: nxt_st.mode = EFRM_FAILSAFE;
                    endcase
                end
            end

            EFRM_FALLBACK: begin
                // Returns to measured speed once encoder is healthy
                if (!enc_lost) begin
                    nxt_st.mode = EFRM_RUN;
                end
            end

            EFRM_FAILSAFE: begin
                nxt_st.mode = EFRM_FAILSAFE;                   // [RULE6]
            end
            default: nxt_st.mode = EFRM_FAILSAFE;
        endcase
        nxt_st.sto = nxt_st.mode == EFRM_FAILSAFE;             // [RULE3] [RULE4]
        nxt_st.est = nxt_st.mode == EFRM_FALLBACK;             // [RULE8]


        // Redundant input request and acknowledgement
        if (ri.discrep) begin
            ev_set[`EFRM_EV_DISCREP] = 1'b1;                   // [RULE12]
        end
        nxt_st.ack_d  = ack_button_i;
        nxt_st.sf_req = ri.request;                            // [RULE11]
        if (ri.request) begin
            nxt_st.sf_ack = 1'b0;
        end else if (!st_ff.sf_ack) begin
            if (st_ff.auto_ack || ack_req ||
                (ack_button_i && !st_ff.ack_d)) begin          // [RULE10]
                if (ri.ack_ok) begin
                    nxt_st.sf_ack = 1'b1;
                end else if (!st_ff.auto_ack) begin
                    ev_set[`EFRM_EV_ACK_REJ] = 1'b1;           // [RULE14]
                end
            end
        end


        // Sticky events: write one clears, a new event wins
        if (wb_cyc_i && wb_stb_i && wb_we_i && !st_ff.ack &&
            efrm_hit(wb_adr_i, `EFRM_OFF_IRQ_ST)) begin
            nxt_st.ev = st_ff.ev & ~clr_w[`EFRM_NEV-1:0];
        end

        nxt_st.ev  = nxt_st.ev | ev_set;
        nxt_st.irq = |(nxt_st.ev & nxt_st.msk);

        // Lock cannot be dropped by software, and the power-up state sets it too
        nxt_st.lock = nxt_st.lock | 1'b1;                      // [RULE9]
    end


    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff          <= '0;
            // Power-up reaction is the safest one: immediate torque off
            st_ff.react    <= 2'(`EFRM_CTRL_RST);
            st_ff.lock     <= 1'b1;
            st_ff.ppr      <= `EFRM_PPR_RST;
            st_ff.mode     <= EFRM_RUN;
            st_ff.sf_ack   <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    assign wb_dat_o       = st_ff.dat;
    assign wb_ack_o       = st_ff.ack;
    assign wb_err_o       = st_ff.err;
    assign sto_o          = st_ff.sto;
    assign use_estimate_o = st_ff.est;
    assign cfg_lock_o     = st_ff.lock;
    assign sf_request_o   = st_ff.sf_req;
    assign sf_acked_o     = st_ff.sf_ack;
    assign irq_o          = st_ff.irq;
endmodule

// File: rtl/efrm_params.svh
// Constants for the encoder fault reaction monitor
`ifndef EFRM_PARAMS_SVH
`define EFRM_PARAMS_SVH
// ---------------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------------
`define EFRM_OFF_CTRL    8'h00
`define EFRM_OFF_STATUS  8'h04
`define EFRM_OFF_IRQ_ST  8'h08
`define EFRM_OFF_IRQ_MSK 8'h0C
`define EFRM_OFF_PPR     8'h10
`define EFRM_OFF_PCNT    8'h14
// ---------------------------------------------------------------------
// Control fields
// ---------------------------------------------------------------------
`define EFRM_CTRL_REACT_LSB 0
`define EFRM_CTRL_AUTO_ACK  2
`define EFRM_CTRL_ACK       3
`define EFRM_CTRL_LOCK      4
// ---------------------------------------------------------------------
// Reaction codes and reset values
// ---------------------------------------------------------------------
`define EFRM_REACT_STO      2'h0
`define EFRM_REACT_DEMAND   2'h1
`define EFRM_REACT_ESTIMATE 2'h2
`define EFRM_CTRL_RST       32'h00000010
`define EFRM_PPR_RST        16'h0400
// ---------------------------------------------------------------------
// Event bits
// ---------------------------------------------------------------------
`define EFRM_EV_GEN_FAULT   0
`define EFRM_EV_COMM_FAULT  1
`define EFRM_EV_ENC_FAULT   2
`define EFRM_EV_ENC_WARN    3
`define EFRM_EV_GEN_WARN    4
`define EFRM_EV_CH1_DIAG    5
`define EFRM_EV_CH2_DIAG    6
`define EFRM_EV_DISCREP     7
`define EFRM_EV_PPR_OK      8
`define EFRM_EV_ACK_REJ     9
`define EFRM_NEV            10
// ---------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------
`define EFRM_CLK_NS         10
`define EFRM_LOSS_NS        1000
`define EFRM_LOSS_CYC       (`EFRM_LOSS_NS / `EFRM_CLK_NS)
`define EFRM_Z_REVS         11
`endif

// File: rtl/efrm_pkg.sv
// Types for the encoder fault reaction monitor
package efrm_pkg;
    typedef enum logic [1:0] {
        EFRM_RUN,
        EFRM_FALLBACK,
        EFRM_FAILSAFE
    } efrm_mode_t;

    typedef enum logic [1:0] {
        EFRM_RI_OK,
        EFRM_RI_LOCKED,
        EFRM_RI_BOTH
    } efrm_ri_t;
endpackage

// File: rtl/efrm_redund.sv
// Dual-channel redundant input checker
`timescale 1ns/1ns
module efrm_redund
    import efrm_pkg::*;
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Channel pair and verdicts
    efrm_ri_if.checker_mp ri
);
    typedef struct packed {
        efrm_ri_t st;
        logic     req;
        logic     dis;
    } efrm_ri_state_t;

    efrm_ri_state_t st_ff;
    efrm_ri_state_t nxt_st;

    // Channels are active high: high means healthy, no request
    always_comb begin
        nxt_st     = st_ff;
        nxt_st.req = !(ri.ch_a && ri.ch_b);        // [RULE11]
        nxt_st.dis = ri.ch_a != ri.ch_b;           // [RULE12] [RULE13]
        case (st_ff.st)
            EFRM_RI_OK: begin
                if (ri.ch_a != ri.ch_b) begin
                    nxt_st.st = EFRM_RI_LOCKED;    // [RULE13]
                end
            end
            EFRM_RI_LOCKED: begin
                // Needs a true joint request before ack may pass
                if (!ri.ch_a && !ri.ch_b) begin
                    nxt_st.st = EFRM_RI_BOTH;      // [RULE13]
                end
            end
            EFRM_RI_BOTH: begin
                if (ri.ch_a != ri.ch_b) begin
                    nxt_st.st = EFRM_RI_LOCKED;
                end else if (ri.ch_a && ri.ch_b) begin
                    nxt_st.st = EFRM_RI_OK;        // [RULE14]
                end
            end
            default: nxt_st.st = EFRM_RI_OK;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '{st: EFRM_RI_OK, req: 1'b0, dis: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign ri.request = st_ff.req;
    assign ri.discrep = st_ff.dis;
    assign ri.ack_ok  = (st_ff.st == EFRM_RI_OK);  // [RULE14]
endmodule

// File: rtl/efrm_ri_if.sv
// Interface between the monitor and its redundant input checker
`timescale 1ns/1ns
interface efrm_ri_if;
    logic ch_a;
    logic ch_b;
    logic request;
    logic discrep;
    logic ack_ok;

    modport checker_mp (
        input  ch_a,
        input  ch_b,
        output request,
        output discrep,
        output ack_ok
    );
    modport user_mp (
        output ch_a,
        output ch_b,
        input  request,
        input  discrep,
        input  ack_ok
    );
endinterface

// File: sim/efrm_enc_model.sv
// Safety encoder model: pulse train, index pulse and a cut channel
`timescale 1ns/1ns
module efrm_enc_model #(
    parameter int PPR = 1024
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic cut_i,
    output logic      ch1_o,
    output logic      ch2_o,
    output logic      pulse_o,
    output logic      z_o
);
    int cnt_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i || cnt_ff == PPR - 1)
            cnt_ff <= 0;
        else
            cnt_ff <= cnt_ff + 1;
    end
    // A cut wire stops pulses too, as a real broken channel would
    assign ch1_o   = !cut_i;
    assign ch2_o   = 1'b1;
    assign pulse_o = !cut_i;
    assign z_o     = (cnt_ff == 0) && !cut_i;
endmodule

// File: sim/efrm_monitor_asserts.sv
// Port checker for the encoder fault reaction monitor
`timescale 1ns/1ns
module efrm_monitor_asserts #(
    parameter int LOSS_CYC = 4
) (
    input logic        clk_i,
    input logic        rst_i,
    input logic        wb_we_i,
    input logic [7:0]  wb_adr_i,
    input logic [3:0]  wb_sel_i,
    input logic [31:0] wb_dat_i,
    input logic        wb_ack_o,
    input logic        enc_ch1_i,
    input logic        enc_ch2_i,
    input logic        sf_active_i,
    input logic        sf_exempt_i,
    input logic        red_ch_a_i,
    input logic        red_ch_b_i,
    input logic        sto_o,
    input logic        use_estimate_o,
    input logic        cfg_lock_o,
    input logic        sf_request_o,
    input logic        irq_o
);
    logic [1:0] react_ff;
    logic [7:0] loss_ff;
    logic [1:0] up_ff;
    logic       seen_ff;
    // Mode is not at the ports, so it is snooped from acked writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            react_ff <= 2'h0;
            loss_ff  <= 8'h00;
            up_ff    <= 2'h0;
            seen_ff  <= 1'b0;
        end else begin
            if (wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0])
                react_ff <= wb_dat_i[1:0];
            if (enc_ch1_i && enc_ch2_i)
                loss_ff <= 8'h00;
            else
                loss_ff <= loss_ff + 8'(loss_ff != 8'hFF);
            up_ff   <= up_ff + 2'(up_ff != 2'h3);
            seen_ff <= seen_ff || (sf_active_i && !sf_exempt_i);
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_lock_held: assert property (cfg_lock_o)
        else $error("drive side config not locked");
    a_sto_immed: assert property (react_ff == 2'h0 &&
        loss_ff == 8'(LOSS_CYC + 3) |-> sto_o)
        else $error("no torque off after encoder loss");
    a_est_switch: assert property (react_ff == 2'h2 &&
        loss_ff == 8'(LOSS_CYC + 3) |-> use_estimate_o && !sto_o)
        else $error("no fallback to estimate");
    a_est_notrip: assert property ($rose(sto_o) |-> react_ff != 2'h2)
        else $error("trip in estimate mode");
    a_demand_gate: assert property (
        $rose(sto_o) && react_ff == 2'h1 |-> seen_ff)
        else $error("demand trip without active function");
    a_failsafe_hold: assert property (sto_o |=> sto_o)
        else $error("fail-safe left without reboot");
    a_req_either: assert property (up_ff == 2'h3 |->
        sf_request_o == $past(!red_ch_a_i || !red_ch_b_i, 2))
        else $error("request does not follow channels");
    a_react_late: assert property (
        $rose(sto_o) || $rose(use_estimate_o) |-> loss_ff >= 8'(LOSS_CYC))
        else $error("reaction before loss time");
    c_sto: cover property ($rose(sto_o));
    c_est: cover property ($rose(use_estimate_o));
    c_irq: cover property ($rose(irq_o));
    c_req: cover property ($rose(sf_request_o));
endmodule
bind efrm_monitor efrm_monitor_asserts #(.LOSS_CYC(LOSS_CYC)) chk_u (
    .clk_i, .rst_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o,
    .enc_ch1_i, .enc_ch2_i, .sf_active_i, .sf_exempt_i, .red_ch_a_i,
    .red_ch_b_i, .sto_o, .use_estimate_o, .cfg_lock_o, .sf_request_o,
    .irq_o);

// File: sim/tb.sv
// Self-checking testbench for the encoder fault reaction monitor
`timescale 1ns/1ns
`include "efrm_params.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    n_fail++; $display("CHECK FAILED %0t got %h exp %h", $time, g, e); \
    end end
module tb;
    localparam int LC = 4;
    logic clk_i = 1'b0, rst_i = 1'b1, cut = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, r;
    logic wb_ack_o, wb_err_o, enc_ch1_i, enc_ch2_i, enc_pulse_i, enc_z_i;
    logic sf_active_i = 1'b0, sf_exempt_i = 1'b0, ack_button_i = 1'b0;
    logic red_ch_a_i = 1'b1, red_ch_b_i = 1'b1;
    logic sto_o, use_estimate_o, cfg_lock_o, sf_request_o, sf_acked_o;
    logic irq_o;
    logic [64:0] exp_q[$], e_m;
    int n_fail = 0, samples_checked = 0, cyc_n = 0, seed = 64;
    efrm_monitor #(.LOSS_CYC(LC), .Z_REVS(11)) dut_u (.clk_i, .rst_i,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .wb_err_o, .enc_ch1_i, .enc_ch2_i,
        .enc_pulse_i, .enc_z_i, .sf_active_i, .sf_exempt_i, .red_ch_a_i,
        .red_ch_b_i, .ack_button_i, .sto_o, .use_estimate_o, .cfg_lock_o,
        .sf_request_o, .sf_acked_o, .irq_o);
    efrm_enc_model enc_u (.clk_i, .rst_i, .cut_i(cut), .ch1_o(enc_ch1_i),
        .ch2_o(enc_ch2_i), .pulse_o(enc_pulse_i), .z_o(enc_z_i));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic results();
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic rst();
        @(posedge clk_i);
        rst_i <= 1'b1;
        cut <= 1'b0;
        sf_active_i <= 1'b0;
        sf_exempt_i <= 1'b0;
        wait_n(3);
        rst_i <= 1'b0;
    endtask
    // Read data is judged by the watcher below, from the queued note
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [64:0] e);
        exp_q.push_back(e);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
        do @(posedge clk_i); while (!(wb_ack_o === 1'b1 || wb_err_o === 1'b1));
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, x);
        bus(1'b0, a, 32'h0, {1'b0, m, x});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 65'h0);
    endtask
    task automatic press();
        ack_button_i <= 1'b1;
        @(posedge clk_i);
        ack_button_i <= 1'b0;
        wait_n(4);
    endtask
    always @(posedge clk_i) begin
        if ((wb_ack_o === 1'b1 || wb_err_o === 1'b1) && exp_q.size() > 0) begin
            e_m = exp_q.pop_front();
            `CHK(wb_err_o, e_m[64])
            `CHK(wb_dat_o & e_m[63:32], e_m[31:0])
        end
        cyc_n++;
        if (cyc_n == 40000) begin
            n_fail++;
            results();
        end
    end
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        rst();
        wait_n(10752);
        rd(`EFRM_OFF_STATUS, 32'h20, 32'h0);
        wait_n(1024);
        rd(`EFRM_OFF_STATUS, 32'h20, 32'h20);
        rd(`EFRM_OFF_IRQ_ST, 32'h100, 32'h100);
        rd(`EFRM_OFF_PCNT, 32'hFFFF, 32'h400);
        rd(`EFRM_OFF_CTRL, 32'h1F, 32'h10);
        wr(`EFRM_OFF_PPR, $random(seed));
        rd(`EFRM_OFF_PPR, 32'hFFFF, 32'h400);
        bus(1'b0, 8'h18, 32'h0, {1'b1, 64'h0});
        `CHK(cfg_lock_o, 1'b1)
        cut <= 1'b1;
        wait_n(LC + 6);
        `CHK(sto_o, 1'b1)
        rd(`EFRM_OFF_IRQ_ST, 32'h3, 32'h3);
        cut <= 1'b0;
        wait_n(10);
        `CHK(sto_o, 1'b1)
        rd(`EFRM_OFF_STATUS, 32'h4C, 32'h48);
        rst();
        wr(`EFRM_OFF_CTRL, {30'h0, `EFRM_REACT_DEMAND});
        cut <= 1'b1;
        wait_n(LC + 10);
        `CHK(sto_o, 1'b0)
        sf_active_i <= 1'b1;
        sf_exempt_i <= 1'b1;
        wait_n(10);
        `CHK(sto_o, 1'b0)
        sf_exempt_i <= 1'b0;
        wait_n(10);
        `CHK(sto_o, 1'b1)
        rd(`EFRM_OFF_IRQ_ST, 32'h5, 32'h5);
        rst();
        wr(`EFRM_OFF_CTRL, {30'h0, `EFRM_REACT_ESTIMATE});
        cut <= 1'b1;
        wait_n(LC + 6);
        `CHK(use_estimate_o, 1'b1)
        `CHK(irq_o, 1'b0)
        rd(`EFRM_OFF_IRQ_ST, 32'h3F, 32'h38);
        rd(`EFRM_OFF_STATUS, 32'hCC, 32'h84);
        wr(`EFRM_OFF_IRQ_MSK, 32'h38);
        wait_n(2);
        `CHK(irq_o, 1'b1)
        sf_active_i <= 1'b1;
        wait_n(10);
        `CHK(sto_o, 1'b0)
        cut <= 1'b0;
        sf_active_i <= 1'b0;
        wait_n(LC + 4);
        `CHK(use_estimate_o, 1'b0)
        wr(`EFRM_OFF_IRQ_ST, 32'h3FF);
        wait_n(2);
        `CHK(irq_o, 1'b0)
        rst();
        r = $random(seed);
        red_ch_a_i <= r[0];
        red_ch_b_i <= !r[0];
        wait_n(4);
        `CHK(sf_request_o, 1'b1)
        rd(`EFRM_OFF_STATUS, 32'h400, 32'h400);
        {red_ch_a_i, red_ch_b_i} <= 2'b11;
        wait_n(4);
        press();
        `CHK(sf_acked_o, 1'b0)
        rd(`EFRM_OFF_IRQ_ST, 32'h200, 32'h200);
        {red_ch_a_i, red_ch_b_i} <= 2'b00;
        wait_n(4);
        rd(`EFRM_OFF_STATUS, 32'h400, 32'h0);
        {red_ch_a_i, red_ch_b_i} <= 2'b11;
        wait_n(4);
        press();
        `CHK(sf_acked_o, 1'b1)
        wr(`EFRM_OFF_CTRL, 32'h4);
        {red_ch_a_i, red_ch_b_i} <= 2'b00;
        wait_n(4);
        `CHK(sf_acked_o, 1'b0)
        {red_ch_a_i, red_ch_b_i} <= 2'b11;
        wait_n(8);
        `CHK(sf_acked_o, 1'b1)
        results();
    end
endmodule
